// ==== hw/sfp_ctrl.sv ====
/*
  Forwarding-policy control of a five-port switch: APB register bank,
  DSCP priority map and a one-cycle forwarding decision per lookup.
  Assumes lookup inputs synchronous to pclk and a separately held
  own MAC address on self_mac.
*/
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int unsigned P_CYC_16  = CYC_16,
  parameter int unsigned P_CYC_64  = CYC_64,
  parameter int unsigned P_CYC_256 = CYC_256
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output var  logic [APB_DW-1:0] prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Own address
  input  wire logic [47:0]       self_mac,
  // Lookup request
  input  wire logic              lk_valid,
  input  wire logic              lk_unknown_vid,
  input  wire logic              lk_unknown_ipmc,
  input  wire logic              lk_is_ip,
  input  wire logic [7:0]        lk_tos,
  input  wire logic [47:0]       lk_src_mac,
  input  wire logic [MAP_W-1:0]  lk_fwd_map,
  input  wire logic [MAP_W-1:0]  lk_ins_basic,
  input  wire logic [MAP_W-1:0]  lk_ins_src,
  // Lookup result
  output var  logic              rs_valid,
  output var  logic [MAP_W-1:0]  rs_port_map,
  output var  logic              rs_drop,
  output var  logic [PRIO_W-1:0] rs_prio,
  output var  logic [MAP_W-1:0]  rs_ins_pvid,
  // Rate-limit controls
  output var  logic              rl_period_tick,
  output var  logic              egress_queue_mode
);

  logic [7:0]        vlan_r;
  logic [7:0]        mc_r;
  logic [7:0]        rate_r;
  logic [7:0]        dscp_r [DSCP_BYTES];
  logic              hit_vlan;
  logic              hit_mc;
  logic              hit_rate;
  logic              hit_dscp;
  logic              hit_any;
  logic [3:0]        d_idx;
  logic [7:0]        rd_nxt;
  logic              setup;
  logic              wr_go;
  logic              self_hit;
  logic [MAP_W-1:0]  map_nxt;
  logic [PRIO_W-1:0] prio_nxt;
  logic [MAP_W-1:0]  ins_nxt;
  logic [TMR_W-1:0]  since_tick_r;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Only writable bits take the new value
  function automatic logic [7:0] wr_merge(input logic [7:0] old,
                                          input logic [7:0] wd,
                                          input logic [7:0] wm);
    wr_merge = (old & ~wm) | (wd & wm);
  endfunction

  // Two-bit priority of one DSCP code
  function automatic logic [PRIO_W-1:0] dscp_pick(input logic [7:0] byt,
                                                  input logic [1:0] sub);
    logic [PRIO_W-1:0] v;
    v = PRIO_NONE;
    unique case (sub)
      2'h0: v = byt[1:0];
      2'h1: v = byt[3:2];
      2'h2: v = byt[5:4];
      2'h3: v = byt[7:6];
    endcase
    dscp_pick = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address decode and read mux

  always_comb begin
    hit_vlan = (paddr == A_VLAN);
    hit_mc   = (paddr == A_MC);
    hit_rate = (paddr == A_RATE);
    hit_dscp = (paddr[APB_AW-1:6] == DSCP_PAGE) && (paddr[1:0] == 2'h0);
    hit_any  = hit_vlan || hit_mc || hit_rate || hit_dscp;
    d_idx    = paddr[5:2];
    rd_nxt   = 8'h00;
    if (hit_vlan) begin
      rd_nxt = vlan_r;
    end else if (hit_mc) begin
      rd_nxt = mc_r;
    end else if (hit_rate) begin
      rd_nxt = rate_r;
    end else if (hit_dscp) begin
      rd_nxt = dscp_r[d_idx];
    end
  end

  assign setup = pce && psel && !penable;
  assign wr_go = pce && psel && penable && pready && pwrite && !pslverr;

  ////////////////////////////////////////////////////////////////////////
  // APB answer: ready in the first cycle of the access phase

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (pce) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !hit_any;
        prdata  <= {RD_PAD, rd_nxt};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Policy registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlan_r <= RST_VLAN;
    end else if (wr_go && hit_vlan) begin
      vlan_r <= wr_merge(vlan_r, pwdata[7:0], WM_VLAN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_r <= RST_MC;
    end else if (wr_go && hit_mc) begin
      mc_r <= wr_merge(mc_r, pwdata[7:0], WM_MC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= RST_RATE;
    end else if (wr_go && hit_rate) begin
      rate_r <= wr_merge(rate_r, pwdata[7:0], WM_RATE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DSCP_BYTES; i++) begin
        dscp_r[i] <= RST_DSCP;
      end
    end else if (wr_go && hit_dscp) begin
      dscp_r[d_idx] <= wr_merge(dscp_r[d_idx], pwdata[7:0], WM_DSCP);
    end
  end

  assign egress_queue_mode = rate_r[B_QMODE];

  ////////////////////////////////////////////////////////////////////////
  // Forwarding decision

  always_comb begin
    self_hit = mc_r[B_SELF_EN] && (lk_src_mac == self_mac);
    if (lk_unknown_vid) begin
      map_nxt = vlan_r[B_FWD_EN] ? vlan_r[MAP_W-1:0] : MAP_NONE;
    end else if (lk_unknown_ipmc && lk_is_ip) begin
      map_nxt = mc_r[B_FWD_EN] ? mc_r[MAP_W-1:0] : MAP_NONE;
    end else begin
      map_nxt = lk_fwd_map;
    end
    if (self_hit) begin
      map_nxt = MAP_NONE;
    end
    prio_nxt = PRIO_NONE;
    if (lk_is_ip) begin
      prio_nxt = dscp_pick(dscp_r[lk_tos[7:4]], lk_tos[3:2]);
    end
    ins_nxt = rate_r[B_PVID_SEL] ? lk_ins_src : lk_ins_basic;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_valid    <= 1'b0;
      rs_port_map <= MAP_NONE;
      rs_drop     <= 1'b0;
      rs_prio     <= PRIO_NONE;
      rs_ins_pvid <= MAP_NONE;
    end else if (pce) begin
      rs_valid <= lk_valid;
      if (lk_valid) begin
        rs_port_map <= map_nxt;
        rs_drop     <= (map_nxt == MAP_NONE);
        rs_prio     <= prio_nxt;
        rs_ins_pvid <= ins_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate-limit period

  sfp_period_tmr #(
    .P_CYC_16  (P_CYC_16),
    .P_CYC_64  (P_CYC_64),
    .P_CYC_256 (P_CYC_256)
  ) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .per_sel (rate_r[PER_HI:PER_LO]),
    .tick    (rl_period_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Enabled cycles since the last tick, for the period check

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_tick_r <= '0;
    end else if (pce) begin
      since_tick_r <= rl_period_tick ? TMR_W'(1) : since_tick_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_vid_fwd_map: assert property (
    pce && lk_valid && lk_unknown_vid && vlan_r[B_FWD_EN] && !self_hit
    |=> rs_valid && rs_port_map == $past(vlan_r[MAP_W-1:0])
        && rs_drop == ($past(vlan_r[MAP_W-1:0]) == MAP_NONE))
    else $error("unknown-VLAN packet not sent by its map");

  a_vid_off_drop: assert property (
    pce && lk_valid && lk_unknown_vid && !vlan_r[B_FWD_EN]
    |=> rs_drop && rs_port_map == MAP_NONE)
    else $error("disabled unknown-VLAN forward did not drop");

  a_ipmc_fwd_map: assert property (
    pce && lk_valid && !lk_unknown_vid && lk_unknown_ipmc && lk_is_ip && !self_hit
    |=> rs_port_map == ($past(mc_r[B_FWD_EN]) ? $past(mc_r[MAP_W-1:0]) : MAP_NONE))
    else $error("unknown IP multicast map wrong");

  a_self_drop: assert property (
    pce && lk_valid && mc_r[B_SELF_EN] && lk_src_mac == self_mac
    |=> rs_drop && rs_port_map == MAP_NONE)
    else $error("self-address packet not filtered");

  a_self_off_pass: assert property (
    pce && lk_valid && !mc_r[B_SELF_EN] && !lk_unknown_vid && !lk_unknown_ipmc
    |=> rs_port_map == $past(lk_fwd_map))
    else $error("known packet altered with filter off");

  a_prio_pick: assert property (
    pce && lk_valid && lk_is_ip && lk_tos[7:2] == 6'h00
    |=> rs_prio == $past(dscp_r[0][1:0]))
    else $error("DSCP code zero priority wrong");

  a_prio_non_ip: assert property (
    pce && lk_valid && !lk_is_ip |=> rs_prio == PRIO_NONE)
    else $error("non-IP frame got a DSCP priority");

  a_pvid_select: assert property (
    pce && lk_valid
    |=> rs_ins_pvid == ($past(rate_r[B_PVID_SEL]) ? $past(lk_ins_src) : $past(lk_ins_basic)))
    else $error("PVID insertion source wrong");

  a_rsv_bits: assert property (
    vlan_r[7:6] == RST_VLAN[7:6] && mc_r[7] == RST_MC[7]
    && rate_r[7:6] == RST_RATE[7:6] && rate_r[1:0] == RST_RATE[1:0])
    else $error("reserved bit changed");

  a_apb_ready: assert property (
    setup |=> pready ##1 (!pready || (psel && !penable)))
    else $error("APB ready timing wrong");

  a_qmode_write: assert property (
    wr_go && hit_rate |=> egress_queue_mode == $past(pwdata[B_QMODE]))
    else $error("egress limit mode not written");

  a_rs_follow: assert property (
    pce |=> rs_valid == $past(lk_valid))
    else $error("result strobe does not follow the lookup strobe");

  a_prio_any: assert property (
    pce && lk_valid && lk_is_ip
    |=> rs_prio == PRIO_W'($past(dscp_r[lk_tos[7:4]]) >> {$past(lk_tos[3:2]), 1'b0}))
    else $error("DSCP priority entry wrong");

  a_ipmc_non_ip: assert property (
    pce && lk_valid && !lk_unknown_vid && lk_unknown_ipmc && !lk_is_ip && !self_hit
    |=> rs_port_map == $past(lk_fwd_map))
    else $error("non-IP frame took the unknown IP multicast map");

  a_unmapped_err: assert property (
    setup && !hit_any
    |=> pready && pslverr && prdata == '0)
    else $error("unmapped address not refused");

  a_unmapped_wr: assert property (
    pce && psel && penable && pready && pslverr
    |=> $stable(vlan_r) && $stable(mc_r) && $stable(rate_r))
    else $error("refused write changed a register");

  a_rd_rate: assert property (
    setup && hit_rate |=> prdata == {RD_PAD, $past(rate_r)})
    else $error("rate control read back wrong");

  a_dscp_write: assert property (
    wr_go && hit_dscp |=> dscp_r[$past(d_idx)] == $past(pwdata[7:0]))
    else $error("priority map byte not written");

  a_freeze_hold: assert property (
    !pce
    |=> $stable(rs_valid) && $stable(rs_port_map) && $stable(pready) && $stable(rl_period_tick)
        && $stable(vlan_r) && $stable(mc_r) && $stable(rate_r))
    else $error("state moved with the clock enable low");

  a_tick_pulse: assert property (
    pce && rl_period_tick |=> !rl_period_tick)
    else $error("period tick longer than one cycle");

  a_tick_bound: assert property (
    since_tick_r <= TMR_W'(P_CYC_256))
    else $error("period tick missing");

endmodule

`default_nettype wire

// ==== hw/sfp_pkg.sv ====
/*
  Constants of the switch forwarding-policy control block: register
  indices, field positions, reset values, write masks and timing.
  Assumes a 20 MHz pclk and an APB master with 32-bit data.
*/
// What this block does
// - Bit 5 of the unknown-VLAN register enables forwarding of unknown-VLAN packets by its port map, else it is off.
// - The unknown-VLAN port map picks egress ports: zero drops, 00001 is port 1, all ones is every port; reset zero.
// - The self-address filter enable (bit 6 of the second register) resets to zero, meaning no filtering.
// - When on, packets whose address equals the switch's own MAC address are dropped at egress.
// - Bit 5 of the second register enables forwarding of unknown IP multicast by its own map; reset zero.
// - The unknown IP multicast port map: zero filters, 00111 is ports 1-3, 01111 ports 1-4, all ones broadcasts.
// - A two-bit field sets the ingress rate-limit period: 00 is 16 ms, 01 is 64 ms, 1x is 256 ms; reset 01.
// - Bit 3 of the third register picks egress rate limiting: 0 per port (reset), 1 per priority queue.
// - With bit 2 of the third register set, PVID insertion is decided per source port by each egress port's setting.
// - With that bit clear, PVID insertion follows only the per-port basic insertion bit, whatever the source.
// - A fully decoded 64-entry DSCP priority map serves both IPv4 and IPv6 frames.
// - The upper six bits of the type-of-service byte select one of 64 entries whose value is the priority.
// - Each entry is two bits; code 0 uses bits 1:0 of the first map byte, each next code the next pair; reset zero.
package sfp_pkg;

  // Bus geometry; byte address is four times the register index
  localparam int unsigned APB_AW     = 10;
  localparam int unsigned APB_DW     = 32;
  localparam logic [7:0]  IDX_VLAN   = 8'h85;
  localparam logic [7:0]  IDX_MC     = 8'h86;
  localparam logic [7:0]  IDX_RATE   = 8'h87;
  localparam logic [7:0]  IDX_DSCP0  = 8'h90;
  localparam int unsigned DSCP_BYTES = 16;
  localparam logic [APB_AW-1:0] A_VLAN = {IDX_VLAN, 2'h0};
  localparam logic [APB_AW-1:0] A_MC   = {IDX_MC, 2'h0};
  localparam logic [APB_AW-1:0] A_RATE = {IDX_RATE, 2'h0};
  localparam logic [3:0]  DSCP_PAGE  = IDX_DSCP0[7:4];
  localparam logic [23:0] RD_PAD     = 24'h000000;

  // Field positions
  localparam int unsigned MAP_W      = 5;
  localparam int unsigned B_FWD_EN   = 5;
  localparam int unsigned B_SELF_EN  = 6;
  localparam int unsigned B_QMODE    = 3;
  localparam int unsigned B_PVID_SEL = 2;
  localparam int unsigned PER_LO     = 4;
  localparam int unsigned PER_HI     = 5;
  localparam int unsigned PRIO_W     = 2;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_VLAN = 8'h00;
  localparam logic [7:0] RST_MC   = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h10;
  localparam logic [7:0] RST_DSCP = 8'h00;
  localparam logic [7:0] WM_VLAN  = 8'h3F;
  localparam logic [7:0] WM_MC    = 8'h7F;
  localparam logic [7:0] WM_RATE  = 8'h3C;
  localparam logic [7:0] WM_DSCP  = 8'hFF;
  localparam logic [4:0] MAP_NONE  = 5'h00;
  localparam logic [1:0] PRIO_NONE = 2'h0;

  // Rate-limit period codes and times
  localparam logic [1:0]  PER_16     = 2'h0;
  localparam logic [1:0]  PER_64     = 2'h1;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned T_P16_MS   = 16;
  localparam int unsigned T_P64_MS   = 64;
  localparam int unsigned T_P256_MS  = 256;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_16     = T_P16_MS * CYC_PER_MS;
  localparam int unsigned CYC_64     = T_P64_MS * CYC_PER_MS;
  localparam int unsigned CYC_256    = T_P256_MS * CYC_PER_MS;
  localparam int unsigned TMR_W      = 23;

endpackage

// ==== hw/sfp_period_tmr.sv ====
/*
  Ingress rate-limit period timer: one-cycle tick at the end of each
  period chosen by the period code.
  Assumes counts above one cycle and below 2**23.
*/
`timescale 1ns/1ps
`default_nettype none

module sfp_period_tmr
  import sfp_pkg::*;
#(
  parameter int unsigned P_CYC_16  = CYC_16,
  parameter int unsigned P_CYC_64  = CYC_64,
  parameter int unsigned P_CYC_256 = CYC_256
) (
  // Clock, reset, enable
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pce,
  // Period code and tick
  input  wire logic [1:0] per_sel,
  output var  logic       tick
);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] last;

  ////////////////////////////////////////////////////////////////////////
  // Period selection, upper code bit wins
  always_comb begin
    if (per_sel[1]) begin
      last = TMR_W'(P_CYC_256 - 1);
    end else if (per_sel == PER_64) begin
      last = TMR_W'(P_CYC_64 - 1);
    end else begin
      last = TMR_W'(P_CYC_16 - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter; a shorter period chosen mid-count ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (pce) begin
      tick <= (cnt_r >= last);
      if (cnt_r >= last) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== sim/tb_sfp_ctrl.sv ====
/*
  Self-checking bench for sfp_ctrl: APB register access, lookup decisions
  compared with a behavioural model, and rate-limit period ticks.
  Assumes package sfp_pkg and shortened period parameters 16/64/256.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sfp_ctrl;
  import sfp_pkg::*;

  localparam int LIMIT = 60000;

  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              pce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [47:0]       self_mac = 48'h0A1B2C3D4E5F;
  logic              lk_valid = 1'b0;
  logic              lk_unknown_vid = 1'b0;
  logic              lk_unknown_ipmc = 1'b0;
  logic              lk_is_ip = 1'b0;
  logic [7:0]        lk_tos = 8'h00;
  logic [47:0]       lk_src_mac = '0;
  logic [MAP_W-1:0]  lk_fwd_map = '0;
  logic [MAP_W-1:0]  lk_ins_basic = '0;
  logic [MAP_W-1:0]  lk_ins_src = '0;
  logic              rs_valid;
  logic [MAP_W-1:0]  rs_port_map;
  logic              rs_drop;
  logic [PRIO_W-1:0] rs_prio;
  logic [MAP_W-1:0]  rs_ins_pvid;
  logic              rl_period_tick;
  logic              egress_queue_mode;
  int                errors = 0;
  int                total_checks = 0;
  int                cyc = 0;
  int                seed = 74697;
  logic [7:0]        mv = RST_VLAN;
  logic [7:0]        mm = RST_MC;
  logic [7:0]        mr = RST_RATE;
  logic [7:0]        md [16];

  sfp_ctrl #(.P_CYC_16(16), .P_CYC_64(64), .P_CYC_256(256)) u_sfp_ctrl (
    .pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .self_mac(self_mac),
    .lk_valid(lk_valid), .lk_unknown_vid(lk_unknown_vid), .lk_unknown_ipmc(lk_unknown_ipmc),
    .lk_is_ip(lk_is_ip), .lk_tos(lk_tos), .lk_src_mac(lk_src_mac), .lk_fwd_map(lk_fwd_map),
    .lk_ins_basic(lk_ins_basic), .lk_ins_src(lk_ins_src), .rs_valid(rs_valid),
    .rs_port_map(rs_port_map), .rs_drop(rs_drop), .rs_prio(rs_prio), .rs_ins_pvid(rs_ins_pvid),
    .rl_period_tick(rl_period_tick), .egress_queue_mode(egress_queue_mode)
  );

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Address table: 16 map bytes, three controls, two unmapped places
  function automatic logic [APB_AW-1:0] adr(input int i);
    logic [7:0] ix;
    ix = IDX_DSCP0 + i[7:0];
    case (i)
      16: return A_VLAN;
      17: return A_MC;
      18: return A_RATE;
      19: return 10'h000;
      20: return 10'h3FC;
      default: return {ix, 2'h0};
    endcase
  endfunction

  function automatic logic [8:0] mrd(input logic [APB_AW-1:0] a);
    if (a == A_VLAN) return {1'b0, mv};
    if (a == A_MC) return {1'b0, mm};
    if (a == A_RATE) return {1'b0, mr};
    if (a[9:6] == DSCP_PAGE && a[1:0] == 2'h0) return {1'b0, md[a[5:2]]};
    return 9'h100;
  endfunction

  function automatic void mwr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    if (a == A_VLAN) mv = (mv & ~WM_VLAN) | (d & WM_VLAN);
    else if (a == A_MC) mm = (mm & ~WM_MC) | (d & WM_MC);
    else if (a == A_RATE) mr = (mr & ~WM_RATE) | (d & WM_RATE);
    else if (a[9:6] == DSCP_PAGE && a[1:0] == 2'h0) md[a[5:2]] = d;
  endfunction

  task automatic apb(input logic [APB_AW-1:0] a, input logic w, input logic [7:0] d);
    logic [31:0] r;
    logic [8:0] e;
    r = $random(seed);
    e = mrd(a);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    if (!w) chk("prdata", {24'h0, e[7:0]}, prdata);
    chk("pslverr", {31'h0, e[8]}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    if (w) mwr(a, d);
  endtask

  task automatic lookup();
    logic [31:0] r;
    logic [5:0] c;
    logic [4:0] m;
    logic [31:0] ep;
    r = $random(seed);
    @(posedge pclk);
    lk_valid <= 1'b1;
    lk_unknown_vid <= r[0];
    lk_unknown_ipmc <= r[1];
    lk_is_ip <= r[2];
    lk_tos <= r[15:8];
    lk_fwd_map <= r[20:16];
    lk_ins_basic <= r[25:21];
    lk_ins_src <= r[30:26];
    lk_src_mac <= r[31] ? self_mac : {16'h0, $random(seed)};
    @(posedge pclk);
    lk_valid <= 1'b0;
    @(posedge pclk);
    c = lk_tos[7:2];
    if (lk_unknown_vid) m = mv[5] ? mv[4:0] : MAP_NONE;
    else if (lk_unknown_ipmc && lk_is_ip) m = mm[5] ? mm[4:0] : MAP_NONE;
    else m = lk_fwd_map;
    if (mm[6] && lk_src_mac == self_mac) m = MAP_NONE;
    chk("rs_valid", 32'h1, {31'h0, rs_valid});
    chk("rs_port_map", {27'h0, m}, {27'h0, rs_port_map});
    chk("rs_drop", {31'h0, m == MAP_NONE}, {31'h0, rs_drop});
    ep = lk_is_ip ? 32'((md[c[5:2]] >> (2 * c[1:0])) & 8'h03) : 32'h0;
    chk("rs_prio", ep, {30'h0, rs_prio});
    chk("rs_ins_pvid", {27'h0, mr[2] ? lk_ins_src : lk_ins_basic}, {27'h0, rs_ins_pvid});
  endtask

  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rl_period_tick !== 1'b1 && n < 1000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [31:0] r;
    for (int i = 0; i < 16; i++) md[i] = RST_DSCP;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then all ones and all zeros against the masks
    for (int i = 0; i < 21; i++) apb(adr(i), 1'b0, 8'h00);
    for (int i = 0; i < 21; i++) begin
      apb(adr(i), 1'b1, 8'hFF);
      apb(adr(i), 1'b0, 8'h00);
      apb(adr(i), 1'b1, 8'h00);
      apb(adr(i), 1'b0, 8'h00);
    end
    // Random configuration interleaved with lookups
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      if (r[1:0] != 2'h0) apb(adr(int'(r[15:8]) % 21), 1'b1, r[31:24]);
      lookup();
    end
    // Period lengths and egress mode for every period code
    for (int c = 0; c < 4; c++) begin
      apb(A_RATE, 1'b1, {2'b00, c[1:0], c[0], 3'b000});
      @(posedge pclk);
      chk("egress_queue_mode", {31'h0, mr[3]}, {31'h0, egress_queue_mode});
      gap(n);
      gap(n);
      chk("period", c == 0 ? 32'd16 : c == 1 ? 32'd64 : 32'd256, n);
    end
    // Clock enable low: nothing moves and the ten frozen cycles do not count
    gap(n);
    pce <= 1'b0;
    lk_valid <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("rs_valid", 32'h0, {31'h0, rs_valid});
    pce <= 1'b1;
    lk_valid <= 1'b0;
    gap(n);
    chk("frozen period", 32'd266, 32'(n + 10));
    print_verdict();
  end

endmodule

`default_nettype wire
